// *** rtl/odc_map.svh ***
// offsets, field positions and reset values of the playback output control registers
// assumes inclusion by the output driver control design and bench files
`ifndef ODC_MAP_SVH
`define ODC_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ODC_ADDR_PWR      8'h25
`define ODC_ADDR_HPD      8'h26
`define ODC_ADDR_RSV      8'h27
`define ODC_ADDR_STG      8'h28
`define ODC_ADDR_RTE      8'h29

// ----------------------------------------------------------------
// reset values and writable bit masks
// ----------------------------------------------------------------
`define ODC_RST_BYTE      8'h00
`define ODC_PWR_WMASK     8'hF0
`define ODC_HPD_WMASK     8'h06
`define ODC_STG_WMASK     8'hFF
`define ODC_RTE_WMASK     8'hFF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ODC_LDAC_BIT      7
`define ODC_RDAC_BIT      6
`define ODC_HEADPHONE_COMMON_OUTPUT_LSB     4
`define ODC_SCP_EN_BIT    2
`define ODC_SCP_MODE_BIT  1
`define ODC_CM_LSB        6
`define ODC_BYPL_LSB      4
`define ODC_BYPR_LSB      2
`define ODC_STEP_LSB      0
`define ODC_ROUTL_LSB     6
`define ODC_ROUTR_LSB     4
`define ODC_LINK_LSB      0

`endif

// *** rtl/odc_pkg.sv ***
// types shared by the playback output control design files
// assumes nothing of its surroundings
package odc_pkg;
    typedef logic [7:0] odc_byte_t;
    typedef logic [1:0] odc_code_t;

    // volume link modes, encoded 0..3 in declaration order
    typedef enum logic [1:0] {
        ODC_LINK_INDEP,
        ODC_LINK_L_FROM_R,
        ODC_LINK_R_FROM_L,
        ODC_LINK_INDEP_ALT
    } odc_link_e;
endpackage

// *** rtl/odc_code_decode.sv ***
// two-bit field code to one-hot select
// assumes the caller registers the result
`timescale 1ns/1ns
`default_nettype none
module odc_code_decode
    import odc_pkg::*;
(
    input  wire odc_code_t code,
    output logic [3:0]     sel
);
    always_comb
    begin
        sel       = 4'h0;
        sel[code] = 1'b1;
    end
endmodule // odc_code_decode
`default_nettype wire

// *** rtl/odc_output_ctrl.sv ***
// playback output control registers and the decoded controls they drive
// assumes a synchronous register port fed by the control bus, one access per cycle
//
// Overview of operation
// - left DAC powered exactly while power register bit 7 is set
// - right DAC powered exactly while power register bit 6 is set
// - common-output field: 00 differential, 01 constant level, 10 single-ended
// - power register low nibble is read-only zero; host writes zeros
// - driver register bit 2 enables short protection on all drivers
// - bit 1 picks current limit (0) or automatic driver power-down (1)
// - register 0x27 reads zero; host never writes it
// - common-mode field picks 1.35, 1.5, 1.65 or 1.8 volts
// - left bypass: off, positive, negative or differential input
// - right bypass: off, positive, negative or differential input
// - soft-step: every sample, every two samples, off; 11 not written
// - left DAC route: one, three to line driver, two to drivers
// - right DAC route: one, three to line driver, two to drivers
// - link 01: left channel takes right volume setting
// - link 10: right channel takes left volume setting
// - link 00 or 11: independent volumes per channel
`timescale 1ns/1ns
`default_nettype none
`include "odc_map.svh"
module odc_output_ctrl
    import odc_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      rst_n,
    input  wire logic      wr_en,
    input  wire logic      rd_en,
    input  wire odc_byte_t addr,
    input  wire odc_byte_t wr_data,
    output odc_byte_t      rd_data,
    input  wire odc_byte_t left_volume_setting,
    input  wire odc_byte_t right_volume_setting,
    output odc_byte_t      left_volume_applied,
    output odc_byte_t      right_volume_applied,
    output logic           left_dac_power_up,
    output logic           right_dac_power_up,
    output logic           headphone_common_output_differential,
    output logic           headphone_common_output_common_mode_level,
    output logic           headphone_common_output_single_ended,
    output logic           short_protect_en,
    output logic           short_limit_current,
    output logic           short_auto_power_down,
    output odc_code_t      common_mode_level_sel,
    output logic [2:0]     second_left_line_bypass,
    output logic [2:0]     second_right_line_bypass,
    output logic           soft_step_per_fs,
    output logic           soft_step_per_2fs,
    output logic           soft_step_off,
    output logic [2:0]     left_converter_route,
    output logic [2:0]     right_converter_route
);

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    odc_byte_t pwr_reg;
    odc_byte_t hpd_reg;
    odc_byte_t stg_reg;
    odc_byte_t rte_reg;
    odc_link_e link_mode;

    // read-only bits are masked to zero on every write, so they hold their zero reset value
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_reg <= `ODC_RST_BYTE;
            hpd_reg <= `ODC_RST_BYTE;
            stg_reg <= `ODC_RST_BYTE;
            rte_reg <= `ODC_RST_BYTE;
        end
        else if (wr_en)
        begin
            unique case (addr)
                `ODC_ADDR_PWR: pwr_reg <= wr_data & `ODC_PWR_WMASK;
                `ODC_ADDR_HPD: hpd_reg <= wr_data & `ODC_HPD_WMASK;
                `ODC_ADDR_STG: stg_reg <= wr_data & `ODC_STG_WMASK;
                `ODC_ADDR_RTE: rte_reg <= wr_data & `ODC_RTE_WMASK;
                default:       ;
            endcase
        end
    end

    assign link_mode = odc_link_e'(rte_reg[`ODC_LINK_LSB +: 2]);

    // ----------------------------------------------------------------
    // register read port
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rd_data <= `ODC_RST_BYTE;
        else if (rd_en)
        begin
            unique case (addr)
                `ODC_ADDR_PWR: rd_data <= pwr_reg;
                `ODC_ADDR_HPD: rd_data <= hpd_reg;
                `ODC_ADDR_STG: rd_data <= stg_reg;
                `ODC_ADDR_RTE: rd_data <= rte_reg;
                default:       rd_data <= `ODC_RST_BYTE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // field decoders
    // ----------------------------------------------------------------
    logic [3:0] headphone_common_output_sel;
    logic [3:0] bypl_sel;
    logic [3:0] bypr_sel;
    logic [3:0] step_sel;
    logic [3:0] routl_sel;
    logic [3:0] routr_sel;

    odc_code_decode u_headphone_common_output (.code(pwr_reg[`ODC_HEADPHONE_COMMON_OUTPUT_LSB +: 2]), .sel(headphone_common_output_sel));
    odc_code_decode u_bypl  (.code(stg_reg[`ODC_BYPL_LSB +: 2]),  .sel(bypl_sel));
    odc_code_decode u_bypr  (.code(stg_reg[`ODC_BYPR_LSB +: 2]),  .sel(bypr_sel));
    odc_code_decode u_step  (.code(stg_reg[`ODC_STEP_LSB +: 2]),  .sel(step_sel));
    odc_code_decode u_routl (.code(rte_reg[`ODC_ROUTL_LSB +: 2]), .sel(routl_sel));
    odc_code_decode u_routr (.code(rte_reg[`ODC_ROUTR_LSB +: 2]), .sel(routr_sel));

    // ----------------------------------------------------------------
    // power and common output controls
    // ----------------------------------------------------------------
    // reserved code 11 leaves every mode select low rather than guess a mode
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_dac_power_up       <= 1'b0;
            right_dac_power_up      <= 1'b0;
            headphone_common_output_differential      <= 1'b0;
            headphone_common_output_common_mode_level <= 1'b0;
            headphone_common_output_single_ended      <= 1'b0;
        end
        else
        begin
            left_dac_power_up       <= pwr_reg[`ODC_LDAC_BIT];
            right_dac_power_up      <= pwr_reg[`ODC_RDAC_BIT];
            headphone_common_output_differential      <= headphone_common_output_sel[0];
            headphone_common_output_common_mode_level <= headphone_common_output_sel[1];
            headphone_common_output_single_ended      <= headphone_common_output_sel[2];
        end
    end

    // ----------------------------------------------------------------
    // short-circuit protection
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            short_protect_en      <= 1'b0;
            short_limit_current   <= 1'b0;
            short_auto_power_down <= 1'b0;
        end
        else
        begin
            short_protect_en      <= hpd_reg[`ODC_SCP_EN_BIT];
            short_limit_current   <= hpd_reg[`ODC_SCP_EN_BIT] & ~hpd_reg[`ODC_SCP_MODE_BIT];
            short_auto_power_down <= hpd_reg[`ODC_SCP_EN_BIT] & hpd_reg[`ODC_SCP_MODE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // output stage level, bypass and soft-stepping
    // ----------------------------------------------------------------
    // bypass bits: [0] positive input, [1] negative input, [2] differential
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            common_mode_level_sel    <= 2'h0;
            second_left_line_bypass  <= 3'h0;
            second_right_line_bypass <= 3'h0;
            soft_step_per_fs         <= 1'b0;
            soft_step_per_2fs        <= 1'b0;
            soft_step_off            <= 1'b0;
        end
        else
        begin
            common_mode_level_sel    <= stg_reg[`ODC_CM_LSB +: 2];
            second_left_line_bypass  <= bypl_sel[3:1];
            second_right_line_bypass <= bypr_sel[3:1];
            soft_step_per_fs         <= step_sel[0];
            soft_step_per_2fs        <= step_sel[1];
            soft_step_off            <= step_sel[2];
        end
    end

    // ----------------------------------------------------------------
    // converter routing and volume link
    // ----------------------------------------------------------------
    // route bits: [0] route one, [1] route three, [2] route two
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_converter_route  <= 3'h0;
            right_converter_route <= 3'h0;
        end
        else
        begin
            left_converter_route  <= routl_sel[2:0];
            right_converter_route <= routr_sel[2:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_volume_applied  <= `ODC_RST_BYTE;
            right_volume_applied <= `ODC_RST_BYTE;
        end
        else
        begin
            unique case (link_mode)
                ODC_LINK_L_FROM_R:
                begin
                    left_volume_applied  <= right_volume_setting;
                    right_volume_applied <= right_volume_setting;
                end
                ODC_LINK_R_FROM_L:
                begin
                    left_volume_applied  <= left_volume_setting;
                    right_volume_applied <= left_volume_setting;
                end
                ODC_LINK_INDEP, ODC_LINK_INDEP_ALT:
                begin
                    left_volume_applied  <= left_volume_setting;
                    right_volume_applied <= right_volume_setting;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic pwr_wr;
    logic stg_wr;
    assign pwr_wr = wr_en && addr == `ODC_ADDR_PWR;
    assign stg_wr = wr_en && addr == `ODC_ADDR_STG;

    property p_ldac;
        pwr_wr |-> ##2 left_dac_power_up == $past(wr_data[7], 2);
    endproperty
    a_ldac: assert property (p_ldac) else $error("left DAC power wrong after write");

    property p_rdac;
        pwr_wr |-> ##2 right_dac_power_up == $past(wr_data[6], 2);
    endproperty
    a_rdac: assert property (p_rdac) else $error("right DAC power wrong after write");

    property p_headphone_common_output;
        pwr_wr && wr_data[5:4] == 2'h2 |-> ##2 headphone_common_output_single_ended && !headphone_common_output_differential && !headphone_common_output_common_mode_level;
    endproperty
    a_headphone_common_output: assert property (p_headphone_common_output) else $error("common output mode not single-ended");

    property p_pwr_rsv;
        rd_en && addr == `ODC_ADDR_PWR |=> rd_data[3:0] == 4'h0;
    endproperty
    a_pwr_rsv: assert property (p_pwr_rsv) else $error("reserved power bits read nonzero");

    property p_scp;
        !short_protect_en |-> !short_limit_current && !short_auto_power_down;
    endproperty
    a_scp: assert property (p_scp) else $error("protection mode active while disabled");

    property p_scp_mode;
        wr_en && addr == `ODC_ADDR_HPD && wr_data[2:1] == 2'h3 |-> ##2 short_auto_power_down && !short_limit_current;
    endproperty
    a_scp_mode: assert property (p_scp_mode) else $error("auto power-down not selected");

    property p_rsv_reg;
        rd_en && addr == `ODC_ADDR_RSV |=> rd_data == 8'h00;
    endproperty
    a_rsv_reg: assert property (p_rsv_reg) else $error("reserved register read nonzero");

    property p_cm;
        stg_wr |-> ##2 common_mode_level_sel == $past(wr_data[7:6], 2);
    endproperty
    a_cm: assert property (p_cm) else $error("common-mode level not applied");

    property p_step_off;
        stg_wr && wr_data[1:0] == 2'h2 |-> ##2 soft_step_off && !soft_step_per_fs && !soft_step_per_2fs;
    endproperty
    a_step_off: assert property (p_step_off) else $error("soft-step not disabled");

    property p_link_l;
        link_mode == ODC_LINK_L_FROM_R |=> left_volume_applied == $past(right_volume_setting);
    endproperty
    a_link_l: assert property (p_link_l) else $error("left volume not following right");

    property p_link_r;
        link_mode == ODC_LINK_R_FROM_L |=> right_volume_applied == $past(left_volume_setting);
    endproperty
    a_link_r: assert property (p_link_r) else $error("right volume not following left");

    c_ldac_up: cover property (pwr_wr && wr_data[7] ##2 left_dac_power_up);
    c_auto_off: cover property (short_auto_power_down);
    c_link_l: cover property (link_mode == ODC_LINK_L_FROM_R ##1 left_volume_applied != 8'h00);
    c_route_two: cover property (left_converter_route[2] && right_converter_route[2]);

endmodule // odc_output_ctrl
`default_nettype wire

// *** tb/odc_host_model.sv ***
// host side of the register port: byte writes and reads
// assumes callers enter its tasks just after a falling clock edge
`timescale 1ns/1ns
`default_nettype none
`include "odc_map.svh"
module odc_host_model
    import odc_pkg::*;
(
    input  wire logic      clock,
    output var logic       wr_en,
    output var logic       rd_en,
    output var odc_byte_t  addr,
    output var odc_byte_t  wr_data,
    input  wire odc_byte_t rd_data
);
    // ------------------------------------------------
    // bus cycles, changed only at falling edges
    // ------------------------------------------------
    initial
    begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
    end

    // raw write: no reserved-bit clean-up, for refusal tests
    task automatic wr_raw(input odc_byte_t a, input odc_byte_t d);
        wr_en = 1'b1;
        rd_en = 1'b0;
        addr = a;
        wr_data = d;
        @(negedge clock);
    endtask

    // well-behaved write; callers never pass reserved codes 11
    task automatic wr(input odc_byte_t a, input odc_byte_t d);
        odc_byte_t m;
        m = d;
        if (a == `ODC_ADDR_PWR) m[3:0] = 4'h0;
        if (a == `ODC_ADDR_HPD) m = m & 8'h06;
        if (a == `ODC_ADDR_RTE) m[2+:2] = 2'h0;
        if (a != `ODC_ADDR_RSV) wr_raw(a, m);
    endtask

    task automatic rd(input odc_byte_t a, output odc_byte_t d);
        rd_en = 1'b1;
        wr_en = 1'b0;
        addr = a;
        @(negedge clock);
        d = rd_data;
    endtask

    // idle lines show inverted junk, not the last value
    task automatic idle();
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = ~addr;
        wr_data = ~wr_data;
        @(negedge clock);
    endtask
endmodule // odc_host_model
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the playback output control registers
// assumes the host model drives the register port at falling edges
`timescale 1ns/1ns
`default_nettype none
`include "odc_map.svh"
module testbench
    import odc_pkg::*;
;
    logic       clock, rst_n, wr_en, rd_en;
    odc_byte_t  addr, wr_data, rd_data, lvs, rvs, lva, rva;
    logic       ldp, rdp, hd, hc, hs, spe, slc, sap, s1, s2, s0;
    odc_code_t  cm;
    logic [2:0] bl, br, rl, rr;
    logic [1:0] c, e;
    int         n_mismatch = 0;
    int         check_count = 0;

    // ------------------------------------------------
    // design, host and clock
    // ------------------------------------------------
    odc_output_ctrl i_dut (.clock(clock), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .left_volume_setting(lvs),
        .right_volume_setting(rvs), .left_volume_applied(lva), .right_volume_applied(rva),
        .left_dac_power_up(ldp), .right_dac_power_up(rdp), .headphone_common_output_differential(hd),
        .headphone_common_output_common_mode_level(hc), .headphone_common_output_single_ended(hs), .short_protect_en(spe),
        .short_limit_current(slc), .short_auto_power_down(sap), .common_mode_level_sel(cm),
        .second_left_line_bypass(bl), .second_right_line_bypass(br), .soft_step_per_fs(s1),
        .soft_step_per_2fs(s2), .soft_step_off(s0), .left_converter_route(rl),
        .right_converter_route(rr));
    odc_host_model i_host (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .rd_data(rd_data));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ------------------------------------------------
    // compares and helpers
    // ------------------------------------------------
    task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t output got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_rd(input odc_byte_t a, input odc_byte_t exp);
        odc_byte_t got;
        i_host.rd(a, got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t read %h got %h exp %h", $time, a, got, exp);
        end
    endtask

    function automatic logic [2:0] f_byp(input logic [1:0] k);
        return (k == 2'h0) ? 3'h0 : 3'(3'h1 << (k - 2'h1));
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset();
        rst_n = 1'b0;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        for (int i = 0; i < 5; i++)
            cmp_rd(8'h25 + 8'(i), 8'h00);
        cmp_rd(8'h30, 8'h00);
        i_host.idle();
        // zeroed codes decode to differential, per-sample stepping and route one
        cmp_out({ldp, rdp, hd, hc, hs, spe, slc, sap}, 8'h20);
        cmp_out({cm, bl, br}, 8'h00);
        cmp_out({5'h0, s1, s2, s0}, 8'h04);
        cmp_out({2'h0, rl, rr}, 8'h09);
        cmp_out(lva, lvs);
        cmp_out(rva, rvs);
    endtask

    task automatic t_power();
        logic [1:0] p;
        p = 2'h0;
        for (int i = 0; i < 4; i++)
        begin
            c = 2'(i % 3); // common-output code 11 never written
            i_host.wr(`ODC_ADDR_PWR, {i[1:0], c, 4'hF});
            cmp_out({6'h0, ldp, rdp}, {6'h0, p});
            p = i[1:0];
            i_host.idle();
            cmp_out({6'h0, ldp, rdp}, {6'h0, p});
            cmp_out({5'h0, hd, hc, hs}, {5'h0, 3'h4 >> c});
            cmp_rd(`ODC_ADDR_PWR, {i[1:0], c, 4'h0});
        end
    endtask

    task automatic t_reserved();
        // common-output field kept at a legal code while the low nibble is set
        i_host.wr_raw(`ODC_ADDR_PWR, 8'hEF);
        i_host.wr_raw(`ODC_ADDR_HPD, 8'hFF);
        i_host.wr_raw(`ODC_ADDR_RSV, 8'hFF);
        i_host.wr_raw(8'h30, 8'hFF);
        cmp_rd(`ODC_ADDR_PWR, 8'hE0);
        cmp_rd(`ODC_ADDR_HPD, 8'h06);
        cmp_rd(`ODC_ADDR_RSV, 8'h00);
        cmp_rd(8'h30, 8'h00);
    endtask

    task automatic t_short();
        for (int i = 0; i < 4; i++)
        begin
            i_host.wr(`ODC_ADDR_HPD, {5'h1F, i[1:0], 1'b1});
            i_host.idle();
            cmp_out({5'h0, spe, slc, sap}, {5'h0, i[1], i[1] & ~i[0], i[1] & i[0]});
        end
    endtask

    task automatic t_stage();
        for (int i = 0; i < 4; i++)
        begin
            c = 2'(i % 3); // soft-step code 11 never written
            i_host.wr(`ODC_ADDR_STG, {i[1:0], i[1:0], ~i[1:0], c});
            i_host.idle();
            cmp_out({6'h0, cm}, {6'h0, i[1:0]});
            cmp_out({2'h0, bl, br}, {2'h0, f_byp(i[1:0]), f_byp(~i[1:0])});
            cmp_out({5'h0, s1, s2, s0}, {5'h0, 3'h4 >> c});
            cmp_rd(`ODC_ADDR_STG, {i[1:0], i[1:0], ~i[1:0], c});
        end
    endtask

    task automatic t_route();
        lvs = 8'h12;
        rvs = 8'h9A;
        for (int i = 0; i < 4; i++)
        begin
            c = 2'(i % 3); // route code 11 never written
            e = 2'((i + 1) % 3);
            i_host.wr(`ODC_ADDR_RTE, {c, e, 2'h3, i[1:0]});
            i_host.idle();
            cmp_out({2'h0, rl, rr}, {2'h0, 3'(3'h1 << c), 3'(3'h1 << e)});
            cmp_out(lva, (i == 1) ? 8'h9A : 8'h12);
            cmp_out(rva, (i == 2) ? 8'h12 : 8'h9A);
            cmp_rd(`ODC_ADDR_RTE, {c, e, 2'h0, i[1:0]});
        end
    endtask

    // ------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------
    initial
    begin
        lvs = 8'h00;
        rvs = 8'h00;
        t_reset();
        t_power();
        t_reserved();
        t_short();
        t_stage();
        t_route();
        t_reset();
        summarize();
    end

    // whole run is under a hundred cycles
    initial
    begin
        #(100 * 3000);
        n_mismatch++;
        summarize();
    end
endmodule // testbench
`default_nettype wire
